// ===== verilog/ssc_scan_sequencer.sv
// Operation
// - Repeat count accepts 1 to 32767 only; default and reset value is 1.
// - Count readback gives stored value; minimum reads 1, maximum reads 32767.
// - Monitored card is 1 to 99 or automatic; automatic follows last switched card.
// - Monitor enable shows selected card state; cleared shows nothing; reset clears it.
// - Monitor shows empty when no channel closed, else the closed channel numbers.
// - Continuous mode wraps from list end to first channel forever; reset disables it.
// - Continuous scan ends on abort, but downloaded lists only on reset.
// - Counted mode: list end opens last channel, restarts if cycles remain.
// - Counted mode stops once completed cycles equal the repeat count.
// - Downloaded lists ignore repeat count; only continuous mode repeats them.
// - Continuous-mode readback is 1 when enabled, 0 when disabled.
// - Start closes first list channel; each trigger advances to the next one.
// - Start with an invalid channel list is refused and flags an error.
// - With trigger-out enabled, each scan closure starts an active-low pulse or restarts a running one.
// - No trigger-out pulses for downloaded lists, digital bus or immediate source.
// - Trigger-out enable reads 1 or 0; reset disables the port.
// - Trigger output is shared; pulse only while holding the reservation.
// - Abort idles the scan, except a running downloaded continuous one, and keeps the list and configuration.
//
// The address map and register access over Avalon-MM are this design's own decisions.
module ssc_scan_sequencer
    import ssc_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire ssc_avs_req_t avs_req_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    input wire logic trig_i,
    input wire logic switch_card_valid_i,
    input wire logic [6:0] switch_card_i,
    input wire logic trig_out_grant_i,
    output logic trig_out_req_o,
    output logic trig_out_n_o,
    output logic scanning_o,
    output logic closed_valid_o,
    output ssc_entry_t closed_entry_o,
    output ssc_mon_t monitor_o,
    output logic irq_o
);

    function automatic logic [31:0] be_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] be);
        logic [31:0] r;
        r = old_v;
        for (int b = 0; b < 4; b++) begin
            if (be[b]) begin
                r[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic list_ok(input ssc_entry_t [LIST_DEPTH-1:0] l, input logic [5:0] n);
        logic ok;
        ok = (n != 6'h00) && (n <= LIST_DEPTH_V);
        for (int i = 0; i < LIST_DEPTH; i++) begin
            if (6'(i) < n && l[i].card > CARD_MAX) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction

    ssc_state_t s_reg;
    ssc_state_t s_next;
    logic req;
    logic acc;
    logic do_wr;
    logic [31:0] rd;
    logic [31:0] wm;
    logic [31:0] cmd;
    logic [IRQ_W-1:0] ev;
    logic [IRQ_W-1:0] w1c;
    logic downloaded;
    logic list_valid;
    logic close_ev;
    logic stop_ev;
    logic fire;
    logic [14:0] cyc_inc;
    logic [6:0] sel_card;
    logic [4:0] list_idx;

    assign req = avs_req_i.read | avs_req_i.write;
    assign list_idx = avs_req_i.address[6:2];
    assign downloaded = (s_reg.src == SRC_DIGITAL_BUS_TRIGGER) || (s_reg.src == SRC_IMMEDIATE_TRIGGER);
    assign list_valid = list_ok(s_reg.list, s_reg.len);
    assign cyc_inc = s_reg.cycles + 15'h0001;

    // Read multiplexer over the current register contents.
    always_comb begin
        rd = 32'h0000_0000;
        if (avs_req_i.address[LIST_SEL_BIT]) begin
            rd[10:0] = s_reg.list[list_idx];
        end else begin
            unique case (avs_req_i.address)
                OFS_CTRL: begin
                    rd[CTRL_CONT] = s_reg.cont;
                    rd[CTRL_TOUT_EN] = s_reg.tout_en;
                    rd[CTRL_MON_EN] = s_reg.mon_en;
                    rd[CTRL_FOUR_WIRE] = s_reg.four_wire;
                    rd[CTRL_SRC_LSB +: 3] = s_reg.src;
                end
                OFS_COUNT: rd[14:0] = s_reg.count;
                OFS_COUNT_MIN: rd[14:0] = COUNT_MIN;
                OFS_COUNT_MAX: rd[14:0] = COUNT_MAX;
                OFS_MONCARD: begin
                    rd[6:0] = s_reg.mon_card;
                    rd[MONCARD_AUTO] = s_reg.mon_auto;
                end
                OFS_LIST_LEN: rd[5:0] = s_reg.len;
                OFS_STATUS: begin
                    rd[0] = (s_reg.state == SCAN_RUN);
                    rd[1] = s_reg.closed;
                    rd[2] = downloaded;
                    rd[3] = list_valid;
                    rd[STS_IDX_LSB +: 5] = s_reg.idx;
                    rd[STS_CYC_LSB +: 15] = s_reg.cycles;
                end
                OFS_IRQ_STS: rd[IRQ_W-1:0] = s_reg.irq_sts;
                OFS_IRQ_MASK: rd[IRQ_W-1:0] = s_reg.irq_mask;
                OFS_LAST_CARD: rd[6:0] = s_reg.last_card;
                OFS_CLOSED: rd[10:0] = s_reg.closed ? s_reg.cur : 11'h000;
                default: rd = 32'h0000_0000;
            endcase
        end
    end

    always_comb begin
        s_next = s_reg;
        ev = '0;
        w1c = '0;
        close_ev = 1'b0;
        stop_ev = 1'b0;
        cmd = 32'h0000_0000;
        wm = 32'h0000_0000;

        // One wait state: the request is seen, then answered the next cycle.
        acc = req && !s_reg.ack;
        s_next.ack = acc;
        do_wr = avs_req_i.write && s_reg.ack;
        if (acc && avs_req_i.read) begin
            s_next.rdata = rd;
        end

        if (do_wr) begin
            wm = be_merge(rd, avs_req_i.writedata, avs_req_i.byteenable);
            if (avs_req_i.address[LIST_SEL_BIT]) begin
                s_next.list[list_idx] = wm[10:0];
            end else begin
                unique case (avs_req_i.address)
                    OFS_CTRL: begin
                        s_next.cont = wm[CTRL_CONT];
                        s_next.tout_en = wm[CTRL_TOUT_EN];
                        s_next.mon_en = wm[CTRL_MON_EN];
                        s_next.four_wire = wm[CTRL_FOUR_WIRE];
                        s_next.src = wm[CTRL_SRC_LSB +: 3];
                    end
                    OFS_COUNT: begin
                        // Out-of-range values leave the stored count untouched.
                        if (wm >= 32'(COUNT_MIN) && wm <= 32'(COUNT_MAX)) begin
                            s_next.count = wm[14:0];
                        end else begin
                            ev[IRQ_PARAM_ERR] = 1'b1;
                        end
                    end
                    OFS_CMD: cmd = avs_req_i.writedata & be_merge(32'h0000_0000, 32'hFFFF_FFFF,
                                                                 avs_req_i.byteenable);
                    OFS_MONCARD: begin
                        if (wm[MONCARD_AUTO]) begin
                            s_next.mon_auto = 1'b1;
                        end else if (wm[31:0] >= 32'(CARD_MIN) && wm[31:0] <= 32'(CARD_MAX)) begin
                            s_next.mon_auto = 1'b0;
                            s_next.mon_card = wm[6:0];
                        end else begin
                            ev[IRQ_PARAM_ERR] = 1'b1;
                        end
                    end
                    OFS_LIST_LEN: s_next.len = wm[5:0];
                    OFS_IRQ_STS: w1c = avs_req_i.writedata[IRQ_W-1:0];
                    OFS_IRQ_MASK: s_next.irq_mask = wm[IRQ_W-1:0];
                    default: begin
                    end
                endcase
            end
        end

        // Reset outranks abort, abort outranks start, and a command outranks a trigger.
        if (cmd[CMD_RESET]) begin
            s_next.count = COUNT_RST;
            s_next.cont = 1'b0;
            s_next.tout_en = 1'b0;
            s_next.mon_en = 1'b0;
            s_next.mon_auto = 1'b1;
            s_next.state = SCAN_IDLE;
            s_next.closed = 1'b0;
            s_next.idx = 5'h00;
            s_next.cycles = 15'h0000;
        end else if (cmd[CMD_ABORT]) begin
            // A downloaded continuous scan runs without the controller and ignores abort.
            if (!(s_reg.state == SCAN_RUN && downloaded && s_reg.cont)) begin
                s_next.state = SCAN_IDLE;
                s_next.closed = 1'b0;
                s_next.idx = 5'h00;
                s_next.cycles = 15'h0000;
            end
        end else if (cmd[CMD_START]) begin
            if (!list_valid) begin
                ev[IRQ_START_ERR] = 1'b1;
            end else begin
                s_next.state = SCAN_RUN;
                s_next.idx = 5'h00;
                s_next.cycles = 15'h0000;
                close_ev = 1'b1;
            end
        end else if (s_reg.state == SCAN_RUN && trig_i) begin
            if ({1'b0, s_reg.idx} + 6'h01 < s_reg.len) begin
                s_next.idx = s_reg.idx + 5'h01;
                close_ev = 1'b1;
            end else begin
                s_next.cycles = cyc_inc;
                if (s_reg.cont) begin
                    s_next.idx = 5'h00;
                    close_ev = 1'b1;
                end else if (downloaded) begin
                    stop_ev = 1'b1;
                end else if (cyc_inc < s_reg.count) begin
                    s_next.idx = 5'h00;
                    close_ev = 1'b1;
                end else begin
                    stop_ev = 1'b1;
                end
            end
        end

        if (stop_ev) begin
            s_next.state = SCAN_IDLE;
            s_next.closed = 1'b0;
            s_next.idx = 5'h00;
            ev[IRQ_DONE] = 1'b1;
        end

        if (close_ev) begin
            s_next.closed = 1'b1;
            s_next.cur = s_reg.list[s_next.idx];
            s_next.last_card = s_reg.list[s_next.idx].card;
            ev[IRQ_CLOSE] = 1'b1;
        end else if (switch_card_valid_i) begin
            s_next.last_card = switch_card_i;
        end

        // A hardware event in the cycle of its clear keeps the bit set.
        s_next.irq_sts = (s_reg.irq_sts & ~w1c) | ev;
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            s_reg <= STATE_RST;
        end else if (ce_i) begin
            s_reg <= s_next;
        end
    end

    // A pulse only goes out while this block holds the shared output.
    assign fire = close_ev && s_reg.tout_en && !downloaded && trig_out_grant_i && ce_i;
    assign sel_card = s_reg.mon_auto ? s_reg.last_card : s_reg.mon_card;

    ssc_pulse u_pulse (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .fire_i(fire),
        .trig_out_n_o(trig_out_n_o)
    );

    ssc_monitor u_monitor (
        .clk_i(clk_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .enable_i(s_reg.mon_en),
        .card_i(sel_card),
        .closed_i(s_reg.closed),
        .entry_i(s_reg.cur),
        .four_wire_i(s_reg.four_wire),
        .monitor_o(monitor_o)
    );

    assign avs_waitrequest_o = req && !(s_reg.ack && ce_i);
    assign avs_readdata_o = s_reg.rdata;
    assign trig_out_req_o = s_reg.tout_en;
    assign scanning_o = (s_reg.state == SCAN_RUN);
    assign closed_valid_o = s_reg.closed;
    assign closed_entry_o = s_reg.cur;
    assign irq_o = |(s_reg.irq_sts & s_reg.irq_mask);

endmodule

// ===== verilog/ssc_pkg.sv
package ssc_pkg;

    localparam int unsigned CLK_HZ = 10_000_000;
    localparam int unsigned TOUT_PULSE_NS = 1000;
    localparam int unsigned TOUT_PULSE_CYC_RAW = (TOUT_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned TOUT_PULSE_CYC = (TOUT_PULSE_CYC_RAW < 1) ? 1 : TOUT_PULSE_CYC_RAW;
    localparam logic [3:0] TOUT_PULSE_LEN = 4'(TOUT_PULSE_CYC);

    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_COUNT = 8'h04;
    localparam logic [7:0] OFS_COUNT_MIN = 8'h08;
    localparam logic [7:0] OFS_COUNT_MAX = 8'h0C;
    localparam logic [7:0] OFS_CMD = 8'h10;
    localparam logic [7:0] OFS_MONCARD = 8'h14;
    localparam logic [7:0] OFS_LIST_LEN = 8'h18;
    localparam logic [7:0] OFS_STATUS = 8'h1C;
    localparam logic [7:0] OFS_IRQ_STS = 8'h20;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h24;
    localparam logic [7:0] OFS_LAST_CARD = 8'h28;
    localparam logic [7:0] OFS_CLOSED = 8'h2C;
    localparam int unsigned LIST_SEL_BIT = 7;

    localparam int unsigned CTRL_CONT = 0;
    localparam int unsigned CTRL_TOUT_EN = 1;
    localparam int unsigned CTRL_MON_EN = 2;
    localparam int unsigned CTRL_FOUR_WIRE = 3;
    localparam int unsigned CTRL_SRC_LSB = 4;
    localparam int unsigned CMD_START = 0;
    localparam int unsigned CMD_ABORT = 1;
    localparam int unsigned CMD_RESET = 2;
    localparam int unsigned MONCARD_AUTO = 8;
    localparam int unsigned STS_IDX_LSB = 4;
    localparam int unsigned STS_CYC_LSB = 16;

    localparam int unsigned IRQ_W = 4;
    localparam int unsigned IRQ_START_ERR = 0;
    localparam int unsigned IRQ_DONE = 1;
    localparam int unsigned IRQ_PARAM_ERR = 2;
    localparam int unsigned IRQ_CLOSE = 3;

    localparam logic [14:0] COUNT_MIN = 15'h0001;
    localparam logic [14:0] COUNT_MAX = 15'h7FFF;
    localparam logic [14:0] COUNT_RST = 15'h0001;
    localparam logic [6:0] CARD_MIN = 7'h01;
    localparam logic [6:0] CARD_MAX = 7'h63;
    localparam int unsigned LIST_DEPTH = 32;
    localparam logic [5:0] LIST_DEPTH_V = 6'h20;
    localparam logic [3:0] FOUR_WIRE_OFS = 4'h8;

    localparam logic [2:0] SRC_BUS = 3'h0;
    localparam logic [2:0] SRC_DIGITAL_BUS_TRIGGER = 3'h1;
    localparam logic [2:0] SRC_EXT = 3'h2;
    localparam logic [2:0] SRC_HOLD = 3'h3;
    localparam logic [2:0] SRC_IMMEDIATE_TRIGGER = 3'h4;

    typedef enum logic [0:0] {SCAN_IDLE, SCAN_RUN} ssc_scan_t;

    typedef struct packed {
        logic [6:0] card;
        logic [3:0] chan;
    } ssc_entry_t;

    typedef struct packed {
        logic read;
        logic write;
        logic [7:0] address;
        logic [31:0] writedata;
        logic [3:0] byteenable;
    } ssc_avs_req_t;

    typedef struct packed {
        logic valid;
        logic [1:0] count;
        logic [3:0] chan_a;
        logic [3:0] chan_b;
    } ssc_mon_t;

    typedef struct packed {
        logic active;
        logic [3:0] cnt;
    } ssc_pulse_t;

    typedef struct packed {
        logic ack;
        logic [31:0] rdata;
        logic cont;
        logic tout_en;
        logic mon_en;
        logic four_wire;
        logic [2:0] src;
        logic [14:0] count;
        logic mon_auto;
        logic [6:0] mon_card;
        logic [6:0] last_card;
        logic [5:0] len;
        ssc_entry_t [LIST_DEPTH-1:0] list;
        ssc_scan_t state;
        logic [4:0] idx;
        logic [14:0] cycles;
        logic closed;
        ssc_entry_t cur;
        logic [IRQ_W-1:0] irq_sts;
        logic [IRQ_W-1:0] irq_mask;
    } ssc_state_t;

    localparam ssc_state_t STATE_RST = '{count: COUNT_RST, mon_auto: 1'b1, state: SCAN_IDLE, default: '0};

endpackage

// ===== verilog/ssc_pulse.sv
module ssc_pulse
    import ssc_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic fire_i,
    output logic trig_out_n_o
);

    ssc_pulse_t p_reg;
    ssc_pulse_t p_next;

    // A new closure during a running pulse restarts its count, so the low time stretches with no new low edge.
    always_comb begin
        p_next = p_reg;
        if (fire_i) begin
            p_next.active = 1'b1;
            p_next.cnt = TOUT_PULSE_LEN - 4'h1;
        end else if (p_reg.active) begin
            if (p_reg.cnt == 4'h0) begin
                p_next.active = 1'b0;
            end else begin
                p_next.cnt = p_reg.cnt - 4'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            p_reg <= '0;
        end else if (ce_i) begin
            p_reg <= p_next;
        end
    end

    assign trig_out_n_o = ~p_reg.active;

endmodule

// ===== verilog/ssc_monitor.sv
module ssc_monitor
    import ssc_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic enable_i,
    input wire logic [6:0] card_i,
    input wire logic closed_i,
    input wire ssc_entry_t entry_i,
    input wire logic four_wire_i,
    output ssc_mon_t monitor_o
);

    ssc_mon_t m_reg;
    ssc_mon_t m_next;

    always_comb begin
        m_next = '0;
        m_next.valid = enable_i;
        if (enable_i && closed_i && entry_i.card == card_i) begin
            m_next.chan_a = entry_i.chan;
            // A four-wire closure of channel 8 or above also holds the sense channel eight below the source channel.
            if (four_wire_i && entry_i.chan >= FOUR_WIRE_OFS) begin
                m_next.count = 2'h2;
                m_next.chan_b = entry_i.chan - FOUR_WIRE_OFS;
            end else begin
                m_next.count = 2'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            m_reg <= '0;
        end else if (ce_i) begin
            m_reg <= m_next;
        end
    end

    assign monitor_o = m_reg;

endmodule

// ===== tb/ssc_scan_sequencer_assertions.sv
module ssc_chk
    import ssc_pkg::*;
(
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire ssc_avs_req_t avs_req_i,
    input wire logic avs_waitrequest_o,
    input wire logic trig_out_grant_i,
    input wire logic trig_out_req_o,
    input wire logic trig_out_n_o,
    input wire logic scanning_o,
    input wire logic closed_valid_o,
    input wire ssc_mon_t monitor_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    a_idle_no_wait: assert property (!avs_req_i.read && !avs_req_i.write |-> !avs_waitrequest_o)
        else $error("waitrequest high without a request");
    a_one_wait_state: assert property ((avs_req_i.read || avs_req_i.write) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("bus access took more than one wait state");
    a_pulse_length: assert property ($fell(trig_out_n_o) |-> (!trig_out_n_o)[*8] ##1 (!trig_out_n_o)[*2])
        else $error("trigger out pulse shorter than ten cycles");
    a_pulse_needs_grant: assert property ($fell(trig_out_n_o) |-> $past(trig_out_req_o && trig_out_grant_i))
        else $error("trigger out pulsed without enable and reservation");
    a_monitor_empty: assert property ($past(!closed_valid_o) |-> monitor_o.count == 2'd0)
        else $error("monitor shows a channel while none is closed");
    a_closed_needs_scan: assert property (!scanning_o |-> !closed_valid_o)
        else $error("channel left closed while idle");
    a_idle_stays: assert property (!scanning_o && !avs_req_i.write |=> !scanning_o)
        else $error("scan started without a command");
    a_reset_state: assert property (!$past(resetn_i) |-> trig_out_n_o && !trig_out_req_o && !scanning_o)
        else $error("outputs not at reset values");

    cover property ($fell(trig_out_n_o));
    cover property ($fell(scanning_o));
    cover property (monitor_o.count == 2'd2);
endmodule

bind ssc_scan_sequencer ssc_chk chk_u (
    .clk_i(clk_i), .resetn_i(resetn_i), .avs_req_i(avs_req_i), .avs_waitrequest_o(avs_waitrequest_o),
    .trig_out_grant_i(trig_out_grant_i), .trig_out_req_o(trig_out_req_o), .trig_out_n_o(trig_out_n_o),
    .scanning_o(scanning_o), .closed_valid_o(closed_valid_o), .monitor_o(monitor_o)
);

// ===== tb/ssc_partner.sv
module ssc_partner (
    input wire logic clk_i,
    input wire logic resetn_i,
    input wire logic fire_i,
    input wire logic slow_i,
    input wire logic other_holds_i,
    input wire logic trig_out_req_i,
    output logic trig_o,
    output logic trig_out_grant_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2:0] hold_cnt;
    // A slow grant only lands on the fifth edge that sees the request held.
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            trig_o <= 1'b0;
            trig_out_grant_o <= 1'b0;
            hold_cnt <= 3'h0;
        end else begin
            trig_o <= fire_i;
            if (!trig_out_req_i || other_holds_i) begin
                trig_out_grant_o <= 1'b0;
                hold_cnt <= 3'h0;
            end else if (!slow_i || hold_cnt == 3'h4) begin
                trig_out_grant_o <= 1'b1;
            end else begin
                hold_cnt <= hold_cnt + 3'h1;
            end
        end
    end
endmodule

// ===== tb/ssc_scan_sequencer_tb.sv
module ssc_scan_sequencer_tb
    import ssc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam ssc_entry_t ENT_A = 11'h035;
    localparam ssc_entry_t ENT_B = 11'h03c;
    logic clk_i = 1'b0;
    logic resetn_i = 1'b0;
    ssc_avs_req_t avs_req = '0;
    logic fire = 1'b0;
    logic slow = 1'b1;
    logic other_holds = 1'b0;
    logic sw_valid = 1'b0;
    logic [6:0] sw_card = 7'h00;
    logic [31:0] rdata;
    logic waitreq, trig, grant, tout_req, tout_n, scanning, closed_valid, irq, prev_valid;
    ssc_entry_t closed_entry, prev_entry;
    ssc_mon_t mon;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    ssc_entry_t close_q[$];
    logic [14:0] cnt;
    int err_count = 0;
    int check_count = 0;
    integer seed = 32'h0000_097d;

    ssc_scan_sequencer dut_u (
        .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'b1), .avs_req_i(avs_req), .avs_readdata_o(rdata),
        .avs_waitrequest_o(waitreq), .trig_i(trig), .switch_card_valid_i(sw_valid), .switch_card_i(sw_card),
        .trig_out_grant_i(grant), .trig_out_req_o(tout_req), .trig_out_n_o(tout_n), .scanning_o(scanning),
        .closed_valid_o(closed_valid), .closed_entry_o(closed_entry), .monitor_o(mon), .irq_o(irq)
    );
    ssc_partner partner_u (
        .clk_i(clk_i), .resetn_i(resetn_i), .fire_i(fire), .slow_i(slow), .other_holds_i(other_holds),
        .trig_out_req_i(tout_req), .trig_o(trig), .trig_out_grant_o(grant)
    );

    initial begin
        forever #50 clk_i = ~clk_i;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] expd);
        check_count++;
        if (seen !== expd) begin
            err_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, expd);
        end
    endtask

    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic bus(input logic rd, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_req.read <= rd;
        avs_req.write <= !rd;
        avs_req.address <= a;
        avs_req.writedata <= d;
        avs_req.byteenable <= 4'hf;
        do begin
            @(posedge clk_i);
            n++;
        end while (waitreq !== 1'b0 && n < 50);
        if (n == 50) begin
            err_count++;
            $display("ERROR at %0t: bus access hung", $time);
            give_verdict();
        end
        avs_req.read <= 1'b0;
        avs_req.write <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b0, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hffff_ffff);
        exp_q.push_back(e);
        msk_q.push_back(m);
        bus(1'b1, a, 32'h0000_0000);
    endtask

    // A trigger takes two edges through the partner, so four idle edges leave the closure settled.
    task automatic step(input ssc_entry_t nxt, input logic closes);
        if (closes) close_q.push_back(nxt);
        fire <= 1'b1;
        @(posedge clk_i);
        fire <= 1'b0;
        repeat (4) @(posedge clk_i);
    endtask

    always @(posedge clk_i) begin
        if (avs_req.read && waitreq === 1'b0 && exp_q.size() > 0) begin
            check(rdata & msk_q.pop_front(), exp_q.pop_front());
        end
        if (resetn_i && closed_valid && (!prev_valid || closed_entry !== prev_entry)) begin
            if (close_q.size() == 0) check(32'h0000_0001, 32'h0000_0000);
            else check(32'(closed_entry), 32'(close_q.pop_front()));
        end
        prev_valid <= closed_valid;
        prev_entry <= closed_entry;
    end

    initial begin
        repeat (10) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        rd(OFS_CTRL, 32'h0000_0000);
        rd(OFS_COUNT, 32'h0000_0001);
        rd(OFS_COUNT_MIN, 32'h0000_0001);
        rd(OFS_COUNT_MAX, 32'h0000_7fff);
        rd(OFS_MONCARD, 32'h0000_0100);
        rd(8'h40, 32'h0000_0000);
        $display("test reset values done");
        wr(OFS_IRQ_MASK, 32'h0000_0005);
        cnt = 15'(($random(seed) & 32'h0000_7ffe) + 1);
        wr(OFS_COUNT, {17'h0_0000, cnt});
        wr(OFS_COUNT, 32'h0000_8000);
        wr(OFS_COUNT, 32'h0000_0000);
        rd(OFS_COUNT, {17'h0_0000, cnt});
        check(32'(irq), 32'h0000_0001);
        wr(OFS_IRQ_STS, 32'h0000_000f);
        wr(OFS_MONCARD, 32'h0000_0064);
        rd(OFS_MONCARD, 32'h0000_0100);
        wr(OFS_MONCARD, 32'h0000_0063);
        rd(OFS_MONCARD, 32'h0000_0063);
        sw_valid <= 1'b1;
        sw_card <= 7'h07;
        @(posedge clk_i);
        sw_valid <= 1'b0;
        rd(OFS_LAST_CARD, 32'h0000_0007);
        wr(OFS_CMD, 32'h0000_0001);
        rd(OFS_STATUS, 32'h0000_0000, 32'h0000_0001);
        check(32'(irq), 32'h0000_0001);
        wr(OFS_IRQ_MASK, 32'h0000_0000);
        check(32'(irq), 32'h0000_0000);
        wr(OFS_IRQ_STS, 32'h0000_000f);
        $display("test settings and refusals done");
        wr(8'h80, 32'h0000_0035);
        wr(8'h84, 32'h0000_003c);
        wr(OFS_LIST_LEN, 32'h0000_0002);
        wr(OFS_CTRL, 32'h0000_000e);
        wr(OFS_COUNT, 32'h0000_0002);
        wr(OFS_MONCARD, 32'h0000_0003);
        close_q.push_back(ENT_A);
        wr(OFS_CMD, 32'h0000_0001);
        check(32'(tout_n), 32'h0000_0000);
        @(posedge clk_i);
        check(32'({mon.valid, mon.count, mon.chan_a}), 32'h0000_0055);
        step(ENT_B, 1'b1);
        check(32'(mon), 32'h0000_06c4);
        step(ENT_A, 1'b1);
        step(ENT_B, 1'b1);
        step(ENT_A, 1'b0);
        rd(OFS_STATUS, 32'h0002_0000, 32'h7fff_0001);
        check(32'(mon.count), 32'h0000_0000);
        $display("test counted scan done");
        other_holds <= 1'b1;
        repeat (12) @(posedge clk_i);
        close_q.push_back(ENT_A);
        wr(OFS_CMD, 32'h0000_0001);
        check(32'(tout_n), 32'h0000_0001);
        rd(OFS_STATUS, 32'h0000_0001, 32'h7fff_0001);
        other_holds <= 1'b0;
        wr(OFS_CMD, 32'h0000_0002);
        rd(OFS_STATUS, 32'h0000_0000, 32'h7fff_0001);
        rd(OFS_COUNT, 32'h0000_0002);
        rd(8'h80, 32'h0000_0035);
        wr(OFS_CTRL, 32'h0000_0001);
        // The monitor is registered behind the control bit, so it clears one edge later.
        @(posedge clk_i);
        check(32'(mon.valid), 32'h0000_0000);
        rd(OFS_CTRL, 32'h0000_0001);
        close_q.push_back(ENT_A);
        wr(OFS_CMD, 32'h0000_0001);
        step(ENT_B, 1'b1);
        step(ENT_A, 1'b1);
        step(ENT_B, 1'b1);
        wr(OFS_CMD, 32'h0000_0002);
        rd(OFS_STATUS, 32'h0000_0000, 32'h0000_0001);
        $display("test continuous and abort done");
        wr(OFS_CTRL, 32'h0000_0013);
        // Let the slow reservation land, so only the downloaded list keeps the pulse away.
        repeat (6) @(posedge clk_i);
        close_q.push_back(ENT_A);
        wr(OFS_CMD, 32'h0000_0001);
        check(32'(tout_n), 32'h0000_0001);
        wr(OFS_CMD, 32'h0000_0002);
        rd(OFS_STATUS, 32'h0000_0001, 32'h0000_0001);
        wr(OFS_CMD, 32'h0000_0004);
        rd(OFS_STATUS, 32'h0000_0000, 32'h0000_0001);
        rd(OFS_CTRL, 32'h0000_0010);
        check(32'(tout_req), 32'h0000_0000);
        wr(OFS_COUNT, 32'h0000_0003);
        wr(OFS_CTRL, 32'h0000_0040);
        close_q.push_back(ENT_A);
        wr(OFS_CMD, 32'h0000_0001);
        step(ENT_B, 1'b1);
        step(ENT_A, 1'b0);
        rd(OFS_STATUS, 32'h0001_0000, 32'h7fff_0001);
        $display("test downloaded scans done");
        check(32'(close_q.size() + exp_q.size()), 32'h0000_0000);
        give_verdict();
    end
endmodule
